// >>> logic/bscc_dec_if.sv
`timescale 1ns/1ps
// operand word passed from the executor to the field decoder, decoded fields passed back
interface bscc_dec_if;
  logic [14:0] word;
  logic [6:0]  addr;
  logic [2:0]  bit_idx;
  logic [10:0] literal;

  modport decoder (input word, output addr, output bit_idx, output literal);
  modport user    (output word, input addr, input bit_idx, input literal);
endinterface : bscc_dec_if

// >>> logic/bscc_exec.sv
`timescale 1ns/1ps
// executes bit-skip, call, clear and watchdog-kick operations
module bscc_exec (
  input  wire logic                clock_i,        // instruction clock
  input  wire logic                rst_i,          // sync reset, high
  input  wire logic                op_valid_i,     // operation presented
  input  wire bscc_pkg::bscc_op_t  op_i,           // operation code
  input  wire logic [14:0]         operand_i,      // operand word
  input  wire logic [14:0]         pc_i,           // current program counter
  input  wire logic [7:0]          acc_i,          // accumulator value
  input  wire logic [7:0]          upper_latch_i,  // program_counter_upper_latch
  input  wire logic [7:0]          file_data_i,    // addressed register data
  output logic                     busy_o,         // second cycle in progress
  output logic                     discard_o,      // discard fetched instruction
  output logic                     pc_load_o,      // load new program counter
  output logic [14:0]              pc_next_o,      // counter value to load
  output logic                     push_o,         // push onto stack_top
  output logic [14:0]              stack_top_o,    // value pushed
  output logic                     file_we_o,      // write addressed register
  output logic [6:0]               file_addr_o,    // register address
  output logic [7:0]               file_wdata_o,   // register write data
  output logic                     acc_we_o,       // write accumulator
  output logic [7:0]               acc_wdata_o,    // accumulator write data
  output logic                     zero_set_o,     // set zero flag
  output logic                     watchdog_clr_o, // clear watchdog_counter
  output logic                     prescale_clr_o, // clear watchdog prescaler
  output logic                     watchdog_expiry_flag_n_set_o, // set timeout flag
  output logic                     sleep_entered_flag_n_set_o    // set sleep flag
);

  typedef struct packed {
    bscc_pkg::bscc_state_t state;
    logic                  discard;
    logic                  pc_load;
    logic [14:0]           pc_next;
    logic                  push;
    logic [14:0]           stack_top;
    logic                  file_we;
    logic [6:0]            file_addr;
    logic [7:0]            file_wdata;
    logic                  acc_we;
    logic [7:0]            acc_wdata;
    logic                  zero_set;
    logic                  kick;
  } bscc_regs_t;

  bscc_regs_t r;
  bscc_regs_t next_r;

  bscc_dec_if dec ();

  // operand field split
  assign dec.word = operand_i;
  bscc_field_dec u_dec (
    .dec (dec.decoder)
  );

  // return address for both call forms
  function automatic logic [14:0] ret_addr(input logic [14:0] pc);
    ret_addr = 15'(pc + 15'h0001);
  endfunction : ret_addr

  // next state and one-cycle command pulses
  always_comb begin
    next_r            = r;
    next_r.discard    = 1'b0;
    next_r.pc_load    = 1'b0;
    next_r.push       = 1'b0;
    next_r.file_we    = 1'b0;
    next_r.acc_we     = 1'b0;
    next_r.zero_set   = 1'b0;
    next_r.kick       = 1'b0;
    case (r.state)
      bscc_pkg::BSCC_ST_EXEC: begin
        if (op_valid_i) begin
          case (op_i)
            bscc_pkg::BSCC_OP_SKIP_CLEAR: begin
              if (!file_data_i[dec.bit_idx]) begin
                next_r.discard = 1'b1;
                next_r.state   = bscc_pkg::BSCC_ST_FLUSH;
              end
            end
            bscc_pkg::BSCC_OP_SKIP_SET: begin
              if (file_data_i[dec.bit_idx]) begin
                next_r.discard = 1'b1;
                next_r.state   = bscc_pkg::BSCC_ST_FLUSH;
              end
            end
            bscc_pkg::BSCC_OP_CALL: begin
              next_r.push           = 1'b1;
              next_r.stack_top      = ret_addr(pc_i);
              next_r.pc_load        = 1'b1;
              next_r.pc_next[10:0]  = dec.literal;
              next_r.pc_next[14:11] = upper_latch_i[6:3];
              next_r.discard        = 1'b1;
              next_r.state          = bscc_pkg::BSCC_ST_FLUSH;
            end
            bscc_pkg::BSCC_OP_CALL_ACC: begin
              next_r.push          = 1'b1;
              next_r.stack_top     = ret_addr(pc_i);
              next_r.pc_load       = 1'b1;
              next_r.pc_next[7:0]  = acc_i;
              next_r.pc_next[14:8] = upper_latch_i[6:0];
              next_r.discard       = 1'b1;
              next_r.state         = bscc_pkg::BSCC_ST_FLUSH;
            end
            bscc_pkg::BSCC_OP_CLR_FILE: begin
              next_r.file_we    = 1'b1;
              next_r.file_addr  = dec.addr;
              next_r.file_wdata = bscc_pkg::ZERO_BYTE;
              next_r.zero_set   = 1'b1;
            end
            bscc_pkg::BSCC_OP_CLR_ACC: begin
              next_r.acc_we    = 1'b1;
              next_r.acc_wdata = bscc_pkg::ZERO_BYTE;
              next_r.zero_set  = 1'b1;
            end
            bscc_pkg::BSCC_OP_KICK: begin
              next_r.kick = 1'b1;
            end
            default: begin
              next_r.state = bscc_pkg::BSCC_ST_EXEC;
            end
          endcase
        end
      end
      bscc_pkg::BSCC_ST_FLUSH: begin
        // second cycle executes the forced no-operation
        next_r.state = bscc_pkg::BSCC_ST_EXEC;
      end
      default: begin
        next_r.state = bscc_pkg::BSCC_ST_EXEC;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      r.state      <= bscc_pkg::BSCC_ST_EXEC;
      r.discard    <= 1'b0;
      r.pc_load    <= 1'b0;
      r.pc_next    <= bscc_pkg::PC_RESET;
      r.push       <= 1'b0;
      r.stack_top  <= bscc_pkg::PC_RESET;
      r.file_we    <= 1'b0;
      r.file_addr  <= 7'h00;
      r.file_wdata <= bscc_pkg::ZERO_BYTE;
      r.acc_we     <= 1'b0;
      r.acc_wdata  <= bscc_pkg::ZERO_BYTE;
      r.zero_set   <= 1'b0;
      r.kick       <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // registered outputs; flags other than zero, timeout and sleep never touched
  assign busy_o         = (r.state == bscc_pkg::BSCC_ST_FLUSH);
  assign discard_o      = r.discard;
  assign pc_load_o      = r.pc_load;
  assign pc_next_o      = r.pc_next;
  assign push_o         = r.push;
  assign stack_top_o    = r.stack_top;
  assign file_we_o      = r.file_we;
  assign file_addr_o    = r.file_addr;
  assign file_wdata_o   = r.file_wdata;
  assign acc_we_o       = r.acc_we;
  assign acc_wdata_o    = r.acc_wdata;
  assign zero_set_o     = r.zero_set;
  assign watchdog_clr_o = r.kick;
  assign prescale_clr_o = r.kick;
  assign watchdog_expiry_flag_n_set_o = r.kick;
  assign sleep_entered_flag_n_set_o   = r.kick;

endmodule : bscc_exec

// >>> logic/bscc_field_dec.sv
`timescale 1ns/1ps
// splits the operand word into register address, bit index and literal
module bscc_field_dec (
  bscc_dec_if.decoder dec  // operand word in, fields out
);
  // operand layout: [6:0] address, [9:7] bit index, [10:0] literal
  assign dec.addr    = dec.word[6:0];
  assign dec.bit_idx = dec.word[9:7];
  assign dec.literal = dec.word[10:0];
endmodule : bscc_field_dec

// >>> logic/bscc_pkg.sv
// Operation
// - skip_if_bit_clear: bit zero discards next instruction, two cycles
// - skip_if_bit_set: bit one discards next instruction, two cycles
// - bit tests use 7-bit register address and 3-bit bit index
// - absolute call pushes program counter plus one onto stack top
// - absolute call loads 11-bit literal into program counter bits 10..0
// - absolute call fills counter bits 14..11 from upper latch bits 6..3
// - absolute call takes two instruction cycles
// - accumulator call pushes program counter plus one onto stack
// - accumulator call loads accumulator low, upper latch bits 6..0 high
// - accumulator call takes two instruction cycles
// - register clear writes zero to addressed register, sets zero flag
// - accumulator clear writes zero to accumulator, sets zero flag
// - watchdog kick zeroes watchdog counter and its prescaler
// - watchdog kick sets both active-low timeout and sleep flags
package bscc_pkg;

  localparam int PC_W    = 15;
  localparam int ADDR_W  = 7;
  localparam int BIT_W   = 3;
  localparam int LIT_W   = 11;
  localparam int DATA_W  = 8;

  // operation codes presented by the fetch stage
  typedef enum logic [2:0] {
    BSCC_OP_NONE       = 3'b000,
    BSCC_OP_SKIP_CLEAR = 3'b001,
    BSCC_OP_SKIP_SET   = 3'b010,
    BSCC_OP_CALL       = 3'b011,
    BSCC_OP_CALL_ACC   = 3'b100,
    BSCC_OP_CLR_FILE   = 3'b101,
    BSCC_OP_CLR_ACC    = 3'b110,
    BSCC_OP_KICK       = 3'b111
  } bscc_op_t;

  typedef enum logic [0:0] {
    BSCC_ST_EXEC  = 1'b0,
    BSCC_ST_FLUSH = 1'b1
  } bscc_state_t;

  localparam logic [14:0] PC_RESET   = 15'h0000;
  localparam logic [7:0]  ZERO_BYTE  = 8'h00;
  localparam int          SLOW_CYCLES = 2;
  localparam int          FAST_CYCLES = 1;
  localparam int          LATCH_CALL_LO = 3;

endpackage : bscc_pkg

// >>> test/bit_skip_call_clear_exec_bench.sv
`timescale 1ns/1ps
module bit_skip_call_clear_exec_bench;
  typedef struct packed {logic [9:0] pul; logic [14:0] pc, top; logic [6:0] adr;} bscc_note_t;
  logic clock_i, rst_i, op_valid_i, busy_o, discard_o, pc_load_o, push_o, file_we_o;
  logic acc_we_o, zero_set_o, watchdog_clr_o, prescale_clr_o;
  logic watchdog_expiry_flag_n_set_o, sleep_entered_flag_n_set_o;
  bscc_pkg::bscc_op_t op_i;
  logic [14:0] operand_i, pc_i, pc_next_o, stack_top_o;
  logic [7:0]  acc_i, upper_latch_i, file_data_i, file_wdata_o, acc_wdata_o;
  logic [6:0]  file_addr_o;
  logic [9:0]  pulses;
  int          num_errors = 0, n_checks = 0, cycles = 0;
  bscc_note_t  notes[$];
  bscc_note_t  got;
  // pulse order: discard, load, push, file, acc, zero, four watchdog pulses
  logic [9:0]  tab [8] = '{10'h000, 10'h200, 10'h200, 10'h380, 10'h380, 10'h050, 10'h030, 10'h00f};
  assign pulses = {discard_o, pc_load_o, push_o, file_we_o, acc_we_o, zero_set_o,
    watchdog_clr_o, prescale_clr_o, watchdog_expiry_flag_n_set_o, sleep_entered_flag_n_set_o};
  bscc_exec u_dut (.*);
  // free-running clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic cmp_field(input logic [14:0] g, input logic [14:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp_field
  task automatic report_and_stop;
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // present one op, note its result, offer an accumulator clear while busy
  task automatic do_op(input bscc_pkg::bscc_op_t op, input logic [14:0] opr, pcv,
                       input logic [7:0] acc, lat, fd);
    bscc_note_t n;
    n.pul = tab[op];
    if (op == bscc_pkg::BSCC_OP_SKIP_CLEAR && fd[opr[9:7]]) n.pul = 10'h000;
    if (op == bscc_pkg::BSCC_OP_SKIP_SET && !fd[opr[9:7]]) n.pul = 10'h000;
    n.pc = (op == bscc_pkg::BSCC_OP_CALL) ? {lat[6:3], opr[10:0]} : {lat[6:0], acc};
    n.top = pcv + 15'h0001;
    n.adr = opr[6:0];
    @(posedge clock_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    operand_i <= opr;
    pc_i <= pcv;
    acc_i <= acc;
    upper_latch_i <= lat;
    file_data_i <= fd;
    if (n.pul != 10'h000) notes.push_back(n);
    @(posedge clock_i);
    op_i <= bscc_pkg::BSCC_OP_CLR_ACC;
    op_valid_i <= n.pul[9];
    @(posedge clock_i);
    op_valid_i <= 1'b0;
  endtask : do_op
  // result watcher
  always @(negedge clock_i) if (!rst_i && pulses !== 10'h000) begin
    got = notes.size() > 0 ? notes.pop_front() : '0;
    cmp_field(pulses, got.pul);
    cmp_field(15'(busy_o), 15'(got.pul[9]));
    if (got.pul[8]) cmp_field(pc_next_o, got.pc);
    if (got.pul[7]) cmp_field(stack_top_o, got.top);
    if (got.pul[6]) cmp_field({file_addr_o, file_wdata_o}, {got.adr, 8'h00});
    if (got.pul[5]) cmp_field(acc_wdata_o, 8'h00);
  end
  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    rst_i = 1'b1;
    op_valid_i = 1'b0;
    op_i = bscc_pkg::BSCC_OP_NONE;
    operand_i = 15'h0000;
    pc_i = 15'h0000;
    acc_i = 8'h00;
    upper_latch_i = 8'h00;
    file_data_i = 8'h00;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    void'($urandom(451));
    // first every op at field boundaries, then random mixes
    for (int i = 0; i < 72; i++) begin
      do_op(bscc_pkg::bscc_op_t'(3'(i < 8 ? i : $urandom_range(7))),
            i < 8 ? 15'h7fff : 15'($urandom), 15'($urandom), 8'($urandom), 8'($urandom),
            i < 8 ? 8'h7f : 8'($urandom));
    end
    repeat (3) @(posedge clock_i);
    cmp_field(15'(notes.size()), 15'h0000);
    report_and_stop();
  end
endmodule : bit_skip_call_clear_exec_bench

// >>> test/bscc_exec_checker.sv
`timescale 1ns/1ps
// watches the executor ports for the effect of each taken operation
module bscc_exec_checker (
  input wire logic               clock_i,       // clock
  input wire logic               rst_i,         // reset
  input wire logic               op_valid_i,    // op presented
  input wire bscc_pkg::bscc_op_t op_i,          // op code
  input wire logic [14:0]        operand_i,     // operand
  input wire logic [14:0]        pc_i,          // counter
  input wire logic [7:0]         acc_i,         // accumulator
  input wire logic [7:0]         upper_latch_i, // upper latch
  input wire logic [7:0]         file_data_i,   // register data
  input wire logic               busy_o,        // second cycle
  input wire logic               discard_o,     // flush
  input wire logic               pc_load_o,     // load
  input wire logic [14:0]        pc_next_o,     // target
  input wire logic               push_o,        // push
  input wire logic [14:0]        stack_top_o,   // return address
  input wire logic               file_we_o,     // register write
  input wire logic [6:0]         file_addr_o,   // register address
  input wire logic               acc_we_o,      // accumulator write
  input wire logic [7:0]         acc_wdata_o,   // accumulator data
  input wire logic               zero_set_o,    // zero flag
  input wire logic               watchdog_clr_o, // watchdog clear
  input wire logic               watchdog_expiry_flag_n_set_o // timeout flag
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic hit; // tested register bit
  assign hit = file_data_i[operand_i[9:7]];
  // operation taken at this edge
  sequence s_take(bscc_pkg::bscc_op_t op);
    op_valid_i && !busy_o && op_i == op;
  endsequence
  // flush with busy, then free
  sequence s_flush;
    discard_o && busy_o ##1 !busy_o;
  endsequence
  a_call_target: assert property (
    s_take(bscc_pkg::BSCC_OP_CALL) |=> pc_load_o && pc_next_o ==
    {$past(upper_latch_i[6:3]), $past(operand_i[10:0])}) else $error("call target wrong");
  a_acc_call_target: assert property (
    s_take(bscc_pkg::BSCC_OP_CALL_ACC) |=> pc_load_o && pc_next_o ==
    {$past(upper_latch_i[6:0]), $past(acc_i)}) else $error("accumulator call target wrong");
  a_clear_acc: assert property (
    s_take(bscc_pkg::BSCC_OP_CLR_ACC) |=> acc_we_o && zero_set_o && !busy_o &&
    acc_wdata_o == 8'h00) else $error("accumulator clear wrong");
  a_call_push: assert property (
    op_valid_i && !busy_o && op_i inside {bscc_pkg::BSCC_OP_CALL, bscc_pkg::BSCC_OP_CALL_ACC}
    |=> push_o && !zero_set_o && stack_top_o == $past(pc_i) + 15'h0001 ##0 s_flush)
    else $error("call push wrong");
  a_skip_clear: assert property (
    s_take(bscc_pkg::BSCC_OP_SKIP_CLEAR) ##0 !hit |=> s_flush) else $error("skip clear wrong");
  a_skip_set: assert property (
    s_take(bscc_pkg::BSCC_OP_SKIP_SET) ##0 hit |=> s_flush) else $error("skip set wrong");
  a_skip_pass: assert property (
    op_valid_i && !busy_o && (op_i == bscc_pkg::BSCC_OP_SKIP_CLEAR ? hit :
    op_i == bscc_pkg::BSCC_OP_SKIP_SET && !hit) |=> !discard_o && !busy_o && !zero_set_o)
    else $error("untaken skip wrong");
  a_clear_file: assert property (
    s_take(bscc_pkg::BSCC_OP_CLR_FILE) |=> file_we_o && zero_set_o && !busy_o &&
    file_addr_o == $past(operand_i[6:0])) else $error("register clear wrong");
  a_kick_flags: assert property (
    s_take(bscc_pkg::BSCC_OP_KICK) |=> watchdog_clr_o && watchdog_expiry_flag_n_set_o &&
    !zero_set_o) else $error("watchdog kick wrong");
endmodule : bscc_exec_checker
bind bscc_exec bscc_exec_checker u_chk (.*);
